// file: rtl/sac_cfg.svh
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// Data-space addresses
`define SAC_RESULT_ADDR 8'hd0
`define SAC_CTRL_ADDR 8'hd1

// Control register bit positions
`define SAC_IRQ_EN_BIT 7
`define SAC_DONE_BIT 6
`define SAC_START_BIT 5
`define SAC_POWER_BIT 4

// Control register value after reset
`define SAC_CTRL_RESET 8'h40
`define SAC_DONE_RESET 1'b1
`define SAC_IRQ_EN_RESET 1'b0
`define SAC_POWER_RESET 1'b0

// Converter clock is the system clock divided by twelve
`define SAC_CLK_DIV 4'hc
`define SAC_DIV_LAST 4'hb

// Approximation steps
`define SAC_MSB_INDEX 3'h7
`define SAC_MSB_TRIAL 8'h80
`define SAC_LSB_INDEX 3'h0
`define SAC_ONE_BIT 8'h01
`define SAC_ZERO_BYTE 8'h00

`endif

// file: rtl/sac_pkg.sv
package sac_pkg;

    // Converter sequencer states
    typedef enum logic [1:0]
    {
        SAC_IDLE = 2'b00,
        SAC_ARMED = 2'b01,
        SAC_CONVERT = 2'b10
    } sac_state_type;

endpackage

// file: rtl/sac_clk_div.sv
`timescale 1ns/100ps
`include "sac_cfg.svh"

module sac_clk_div
    import sac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Phase control
    input wire logic restart,
    // Converter step enable
    output logic tick
);

    logic [3:0] count;
    wire at_last = (count == `SAC_DIV_LAST);

    // Restart aligns every step to the conversion launch
    always_ff @(posedge clk)
    begin
        if (reset || restart || at_last)
            count <= 4'h0;
        else
            count <= count + 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            tick <= 1'b0;
        else
            tick <= at_last && !restart;
    end

endmodule

// file: rtl/sac_pin_sync.sv
`timescale 1ns/100ps

module sac_pin_sync
    import sac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Asynchronous level
    input wire logic pin,
    // Settled level
    output logic level
);

    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Accept a change only once two later stages agree
    always_ff @(posedge clk)
    begin
        if (reset)
            level <= 1'b0;
        else if (stage2 == stage3)
            level <= stage3;
    end

endmodule

// file: rtl/sac_control.sv
`timescale 1ns/100ps
`include "sac_cfg.svh"

module sac_control
    import sac_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Data-space register port
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // Core status and option
    input wire logic core_in_wait,
    input wire logic wait_sync_option,
    // Analog front end
    input wire logic comparator_high,
    output logic [7:0] dac_code,
    output logic converter_power_on,
    output logic converter_active,
    // Completion interrupt, vector four
    output logic done_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and decode

    sac_state_type state;
    sac_state_type next_state;
    logic done_irq_enable;
    logic done_flag;
    logic [7:0] conversion_result;
    logic [2:0] bit_index;
    logic comparator_level;
    logic tick;

    wire ctl_sel = (addr == `SAC_CTRL_ADDR);
    wire result_sel = (addr == `SAC_RESULT_ADDR);
    wire ctl_write = wr_en && ctl_sel;
    wire conversion_trigger = ctl_write && wdata[`SAC_START_BIT];
    wire next_power = ctl_write ? wdata[`SAC_POWER_BIT] : converter_power_on;
    wire converting = (state == SAC_CONVERT);
    wire wait_seen = (state == SAC_ARMED) && core_in_wait;

    wire direct_start = conversion_trigger && !wait_sync_option;
    wire load_conv = next_power && (direct_start || (wait_seen && !conversion_trigger));

    wire step = converting && tick && converter_power_on;
    wire finish = step && (bit_index == `SAC_LSB_INDEX);

    ////////////////////////////////////////////////////////////////////////////
    // Successive approximation datapath

    wire [7:0] bit_mask = `SAC_ONE_BIT << bit_index;
    wire [7:0] kept = comparator_level ? bit_mask : `SAC_ZERO_BYTE;
    wire [7:0] resolved = (dac_code & ~bit_mask) | kept;
    wire [7:0] next_trial = resolved | (bit_mask >> 1);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    // divider free-runs; only CONVERT uses its steps
    assign next_state = !next_power ? SAC_IDLE :
                        load_conv ? SAC_CONVERT :
                        (conversion_trigger && wait_sync_option) ? SAC_ARMED :
                        finish ? SAC_IDLE :
                        state;

    always_ff @(posedge clk)
    begin
        if (reset)
            state <= SAC_IDLE;
        else
            state <= next_state;
    end

    // activity level keeps converter clocked in WAIT
    always_ff @(posedge clk)
    begin
        if (reset)
            converter_active <= 1'b0;
        else
            converter_active <= (next_state != SAC_IDLE);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dac_code <= `SAC_ZERO_BYTE;
            bit_index <= `SAC_MSB_INDEX;
        end
        else if (load_conv)
        begin
            dac_code <= `SAC_MSB_TRIAL;
            bit_index <= `SAC_MSB_INDEX;
        end
        else if (step && !finish)
        begin
            dac_code <= next_trial;
            bit_index <= bit_index - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and result registers

    // power bit, enable bit, reset values
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            done_irq_enable <= `SAC_IRQ_EN_RESET;
            converter_power_on <= `SAC_POWER_RESET;
        end
        else if (ctl_write)
        begin
            done_irq_enable <= wdata[`SAC_IRQ_EN_BIT];
            converter_power_on <= wdata[`SAC_POWER_BIT];
        end
    end

    // hardware-only set; start clears
    // Completion in the clearing cycle is kept, set wins
    always_ff @(posedge clk)
    begin
        if (reset)
            done_flag <= `SAC_DONE_RESET;
        else if (finish)
            done_flag <= 1'b1;
        else if (conversion_trigger)
            done_flag <= 1'b0;
    end

    // result capture; same cycle as flag
    always_ff @(posedge clk)
    begin
        if (reset)
            conversion_result <= `SAC_ZERO_BYTE;
        else if (finish)
            conversion_result <= resolved;
    end

    // start reads zero; low nibble unused
    wire [7:0] ctl_view = {done_irq_enable, done_flag, 1'b0, converter_power_on, 4'h0};
    wire [7:0] read_mux = ctl_sel ? ctl_view :
                          result_sel ? conversion_result : `SAC_ZERO_BYTE;

    always_ff @(posedge clk)
    begin
        if (reset)
            rdata <= `SAC_ZERO_BYTE;
        else if (rd_en)
            rdata <= read_mux;
    end

    // enable gating; flag is pending; raise on set
    always_ff @(posedge clk)
    begin
        if (reset)
            done_irq <= 1'b0;
        else
            done_irq <= done_flag && done_irq_enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Divider and comparator input

    sac_clk_div u_div
    (
        .clk(clk),
        .reset(reset),
        .restart(load_conv),
        .tick(tick)
    );

    // Comparator answers from the analog side, outside this clock
    sac_pin_sync u_cmp_sync
    (
        .clk(clk),
        .reset(reset),
        .pin(comparator_high),
        .level(comparator_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence start_written;
        conversion_trigger && !finish;
    endsequence

    sequence start_taken;
        load_conv ##1 converting;
    endsequence

    sequence wait_entered;
        wait_seen && !ctl_write;
    endsequence

    a_irq_enable_gate: assert property (
        ##1 done_irq == $past(done_flag && done_irq_enable))
        else $error("interrupt does not follow flag and enable");

    a_flag_write_ignored: assert property (
        ctl_write && !conversion_trigger && !finish |=> done_flag == $past(done_flag))
        else $error("completion flag changed by plain write");

    a_start_clears_flag: assert property (
        start_written |=> !done_flag)
        else $error("start write did not clear completion flag");

    a_restart_fresh: assert property (
        start_taken |-> bit_index == `SAC_MSB_INDEX && dac_code == `SAC_MSB_TRIAL)
        else $error("restart did not begin at the top bit");

    a_start_reads_zero: assert property (
        rd_en && ctl_sel |=> !rdata[`SAC_START_BIT])
        else $error("start bit read back as one");

    a_power_idle: assert property (
        ctl_write && !wdata[`SAC_POWER_BIT] |=> state == SAC_IDLE && !converter_active)
        else $error("power-down did not idle the converter");

    a_wait_hold: assert property (
        state == SAC_ARMED && !core_in_wait && !ctl_write |=> state == SAC_ARMED)
        else $error("synchronised start left before WAIT");

    // A restart realigns the divider, so spacing starts over
    a_step_spacing: assert property (
        disable iff (reset || load_conv)
        step && !finish && !load_conv |=> !tick [*8] ##1 !tick [*3] ##1 tick)
        else $error("approximation steps not twelve cycles apart");

    a_reset_value: assert property (
        $past(reset) |-> ctl_view == `SAC_CTRL_RESET && state == SAC_IDLE)
        else $error("control register not 40h after reset");

    // Reset itself sets the flag, so that rise carries no result
    a_result_with_flag: assert property (
        $rose(done_flag) && !$past(reset) |->
            $past(finish) && conversion_result == $past(resolved))
        else $error("flag set without fresh result");

    a_start_loads_msb: assert property (
        conversion_trigger && next_power && !wait_sync_option |=>
            converting && dac_code == `SAC_MSB_TRIAL)
        else $error("powered start did not begin at the top bit");

    a_powered_convert: assert property (
        converting |-> converter_power_on)
        else $error("converting while powered down");

    a_sync_arms: assert property (
        conversion_trigger && next_power && wait_sync_option |=> state == SAC_ARMED)
        else $error("synchronised start was not held");

    a_wait_launches: assert property (
        wait_entered |=> converting)
        else $error("conversion did not start in WAIT");

    a_irq_on_flag: assert property (
        $rose(done_flag) && done_irq_enable |=> done_irq)
        else $error("interrupt not raised when flag set");

    a_irq_pending: assert property (
        done_irq |-> $past(done_flag))
        else $error("interrupt without pending flag");

    a_result_read: assert property (
        rd_en && result_sel |=> rdata == $past(conversion_result))
        else $error("result register read wrong value");

    a_unmapped_zero: assert property (
        rd_en && !ctl_sel && !result_sel |=> rdata == `SAC_ZERO_BYTE)
        else $error("unmapped address read non-zero");

    a_result_holds: assert property (
        !finish |=> $stable(conversion_result))
        else $error("result changed without completion");

    a_done_releases_clock: assert property (
        finish && !ctl_write |=> !converter_active)
        else $error("converter still active after completion");

endmodule

// file: sim/sac_analog_model.sv
`timescale 1ns/100ps

module sac_analog_model
(
    // Clock
    input wire logic clk,
    // Converter side
    input wire logic [7:0] dac_code,
    input wire logic converter_power_on,
    // Level on the selected input
    input wire logic [7:0] level,
    // Comparator answer
    output logic comparator_high
);
    initial comparator_high = 1'b0;

    // Unpowered comparator gives no usable answer, so it wanders
    always @(posedge clk)
    begin
        if (converter_power_on)
            comparator_high <= (level >= dac_code);
        else
            comparator_high <= ~comparator_high;
    end
endmodule

// file: sim/sac_control_test.sv
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module sac_control_test;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic core_in_wait = 1'b0;
    logic wait_sync_option = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] level = 8'h00;
    logic [7:0] rdata;
    logic [7:0] dac_code;
    logic comparator_high;
    logic converter_power_on;
    logic converter_active;
    logic done_irq;
    int err_total = 0;
    int cmp_count = 0;
    int n;

    always #5 clk = ~clk;

    sac_control u_dut (.clk(clk), .reset(reset), .addr(addr), .wr_en(wr_en),
        .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .core_in_wait(core_in_wait),
        .wait_sync_option(wait_sync_option), .comparator_high(comparator_high),
        .dac_code(dac_code), .converter_power_on(converter_power_on),
        .converter_active(converter_active), .done_irq(done_irq));

    sac_analog_model u_model (.clk(clk), .dac_code(dac_code),
        .converter_power_on(converter_power_on), .level(level),
        .comparator_high(comparator_high));

    ////////////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(posedge clk);
        #1 wr_en = 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #1 addr = a;
        rd_en = 1'b1;
        @(posedge clk);
        #1 rd_en = 1'b0;
        `CHK(rdata, e)
    endtask

    // Counts cycles until the sequencer goes idle
    task wait_idle;
        n = 0;
        while (converter_active !== 1'b0)
        begin
            cyc(1);
            n++;
            if (n > 400)
            begin
                err_total++;
                results();
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task t_plain;
        level = 8'h5a;
        wr(8'hd1, 8'hb0);
        `CHK(converter_active, 1'b1)
        `CHK(dac_code, 8'h80)
        rd(8'hd1, 8'h90);
        wait_idle();
        `CHK(n inside {[90:100]}, 1'b1)
        rd(8'hd0, 8'h5a);
        rd(8'hd1, 8'hd0);
        `CHK(done_irq, 1'b1)
    endtask

    task t_noirq;
        level = 8'hff;
        wr(8'hd1, 8'h30);
        wait_idle();
        rd(8'hd1, 8'h50);
        `CHK(done_irq, 1'b0)
        rd(8'hd0, 8'hff);
    endtask

    task t_restart;
        level = 8'h33;
        wr(8'hd1, 8'hb0);
        cyc(40);
        wr(8'hd1, 8'hd0);
        rd(8'hd1, 8'h90);
        level = 8'h00;
        wr(8'hd1, 8'hb0);
        `CHK(dac_code, 8'h80)
        wait_idle();
        `CHK(n inside {[90:100]}, 1'b1)
        rd(8'hd0, 8'h00);
    endtask

    task t_power;
        wr(8'hd1, 8'hb0);
        cyc(30);
        wr(8'hd1, 8'h00);
        `CHK(converter_power_on, 1'b0)
        `CHK(converter_active, 1'b0)
        wr(8'hd1, 8'h20);
        cyc(120);
        `CHK(converter_active, 1'b0)
        rd(8'hd1, 8'h00);
    endtask

    task t_sync;
        wait_sync_option = 1'b1;
        level = 8'ha5;
        wr(8'hd1, 8'hb0);
        cyc(150);
        rd(8'hd1, 8'h90);
        // Core waits long after the start write, once the held start is read back
        core_in_wait = 1'b1;
        wait_idle();
        `CHK(n inside {[90:100]}, 1'b1)
        rd(8'hd0, 8'ha5);
        `CHK(done_irq, 1'b1)
        core_in_wait = 1'b0;
        wait_sync_option = 1'b0;
        rd(8'hd2, 8'h00);
        wr(8'hd0, 8'h12);
        rd(8'hd0, 8'ha5);
    endtask

    task t_midreset;
        wr(8'hd1, 8'hb0);
        cyc(20);
        reset = 1'b1;
        cyc(1);
        reset = 1'b0;
        `CHK(converter_active, 1'b0)
        `CHK(done_irq, 1'b0)
        rd(8'hd1, 8'h40);
    endtask

    initial
    begin
        cyc(20);
        reset = 1'b0;
        rd(8'hd1, 8'h40);
        `CHK(converter_power_on, 1'b0)
        t_plain();
        t_noirq();
        t_restart();
        t_power();
        t_sync();
        t_midreset();
        results();
    end
endmodule
